// ### rtl/rbpt_pkg.sv
// Package: constants, offsets and enumerations of the reading buffer with pre-event capture
package rbpt_pkg;

	// ----------------------------------------------------------------
	// Register map, byte offsets on the register port
	// ----------------------------------------------------------------
	localparam logic [7:0] RBPT_OFF_CTRL     = 8'h00;
	localparam logic [7:0] RBPT_OFF_SIZE     = 8'h04;
	localparam logic [7:0] RBPT_OFF_AUTO     = 8'h08;
	localparam logic [7:0] RBPT_OFF_MCOUNT   = 8'h0C;
	localparam logic [7:0] RBPT_OFF_PRE_PCT  = 8'h10;
	localparam logic [7:0] RBPT_OFF_PRE_CNT  = 8'h14;
	localparam logic [7:0] RBPT_OFF_STATUS   = 8'h18;
	localparam logic [7:0] RBPT_OFF_FREE     = 8'h1C;
	localparam logic [7:0] RBPT_OFF_RESERVED = 8'h20;
	localparam logic [7:0] RBPT_OFF_RD_INDEX = 8'h24;
	localparam logic [7:0] RBPT_OFF_RD_DATA  = 8'h28;
	localparam logic [7:0] RBPT_OFF_RD_TAG   = 8'h2C;
	localparam logic [7:0] RBPT_OFF_RD_TS    = 8'h30;

	// ----------------------------------------------------------------
	// Control register field positions
	// ----------------------------------------------------------------
	localparam int RBPT_CTRL_MODE_LSB = 0;   // 2 bits, storage mode
	localparam int RBPT_CTRL_FEED_LSB = 2;   // 2 bits, reading source
	localparam int RBPT_CTRL_EGRP_BIT = 4;   // element_set_select, 1 = compact
	localparam int RBPT_CTRL_PSRC_LSB = 5;   // 2 bits, pre-event source
	localparam int RBPT_CTRL_LINK_LSB = 8;   // 3 bits, link line
	localparam int RBPT_CTRL_CLR_BIT  = 16;  // write 1: clear buffer
	localparam int RBPT_CTRL_BTRG_BIT = 17;  // write 1: bus trigger
	localparam int RBPT_CTRL_MODE_WE  = 18;  // write 1: mode field is taken
	localparam int RBPT_DEF_BIT       = 31;  // write 1: take the default value
	localparam int RBPT_INF_BIT       = 31;  // measure count infinite

	// ----------------------------------------------------------------
	// Reset values and limits
	// ----------------------------------------------------------------
	localparam logic [14:0] RBPT_SIZE_RST    = 15'h0064;  // 100 entries
	localparam logic [14:0] RBPT_SIZE_MIN    = 15'h0002;
	localparam logic [14:0] RBPT_PRE_RST     = 15'h0032;  // half of 100
	localparam logic [6:0]  RBPT_PCT_DEF     = 7'h32;     // 50 percent
	localparam logic [6:0]  RBPT_PCT_MAX     = 7'h64;     // 100 percent
	localparam logic [16:0] RBPT_MCOUNT_RST  = 17'h00001;
	localparam logic [21:0] RBPT_PCT_DIV     = 22'h000064;

	// ----------------------------------------------------------------
	// Enumerations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RBPT_STORAGE_DISABLED_MODE,
		RBPT_MODE_ONCE,
		RBPT_MODE_ALWAYS,
		RBPT_MODE_PRE
	} rbpt_mode_e;

	typedef enum logic [1:0] {
		RBPT_FEED_RAW,
		RBPT_FEED_MATH_RESULT_SOURCE,
		RBPT_FEED_NONE,
		RBPT_FEED_NONE2
	} rbpt_feed_e;

	typedef enum logic [1:0] {
		RBPT_SRC_EXT,
		RBPT_SRC_CHAINED_INSTRUMENT_TRIGGER,
		RBPT_SRC_BUS,
		RBPT_SRC_KEY
	} rbpt_src_e;

endpackage

// ### rtl/rbpt_buffer.sv
// Reading buffer controller with fill-once, continuous and pre-event capture
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

module rbpt_buffer
	import rbpt_pkg::*;
#(
	parameter int          DATA_W      = 32,
	parameter int          DEPTH       = 2027,
	parameter logic [14:0] MAX_FULL    = 15'd404,
	parameter logic [14:0] MAX_COMPACT = 15'd2027,
	parameter logic [31:0] MEM_BYTES   = 32'd16216,
	parameter logic [31:0] FULL_BYTES  = 32'd12,
	parameter logic [31:0] CMP_BYTES   = 32'd8,
	parameter int          LINK_LINES  = 6
) (
	input  wire logic                  clk_i,
	input  wire logic                  reset_i,
	input  wire logic [7:0]            addr_i,
	input  wire logic [31:0]           wdata_i,
	input  wire logic                  wr_i,
	input  wire logic                  rd_i,
	output logic      [31:0]           rdata_o,
	input  wire logic                  raw_valid_i,
	input  wire logic [DATA_W-1:0]     raw_data_i,
	input  wire logic                  math_valid_i,
	input  wire logic [DATA_W-1:0]     math_data_i,
	input  wire logic [3:0]            func_i,
	input  wire logic [7:0]            chan_i,
	input  wire logic                  ext_trig_i,
	input  wire logic [LINK_LINES-1:0] link_trig_i,
	input  wire logic                  key_trig_i,
	input  wire logic                  abort_i,
	output logic                       storing_o,
	output logic                       triggered_o,
	output logic                       error_o
);

	localparam int IW = $clog2(DEPTH);

	// ----------------------------------------------------------------
	// State and storage
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {RBPT_S_IDLE, RBPT_S_RUN, RBPT_S_POST, RBPT_S_DONE} rbpt_state_e;

	rbpt_state_e  state;
	rbpt_mode_e   mode;
	rbpt_feed_e   feed;
	rbpt_src_e    psrc;
	logic         compact;
	logic [2:0]   link_sel;
	logic [14:0]  size;
	logic [14:0]  pre_cnt;
	logic         auto_en;
	logic [16:0]  mcount;
	logic         m_inf;
	logic [14:0]  wptr;
	logic [14:0]  stored;
	logic         base_set;
	logic [31:0]  ts_ctr;
	logic [31:0]  ts_base;
	logic [14:0]  rd_idx;
	logic [DATA_W-1:0] mem_data [DEPTH];
	logic [31:0]  mem_ts   [DEPTH];
	logic [11:0]  mem_tag  [DEPTH];
	logic [DEPTH-1:0] mem_valid;

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	wire logic        w_ctrl  = wr_i && (addr_i == RBPT_OFF_CTRL);
	wire logic        w_size  = wr_i && (addr_i == RBPT_OFF_SIZE);
	wire logic        w_auto  = wr_i && (addr_i == RBPT_OFF_AUTO);
	wire logic        w_mcnt  = wr_i && (addr_i == RBPT_OFF_MCOUNT);
	wire logic        w_pct   = wr_i && (addr_i == RBPT_OFF_PRE_PCT);
	wire logic        w_pcnt  = wr_i && (addr_i == RBPT_OFF_PRE_CNT);
	wire logic        w_ridx  = wr_i && (addr_i == RBPT_OFF_RD_INDEX);
	wire logic        w_stat  = wr_i && (addr_i == RBPT_OFF_STATUS);
	wire logic        clr_cmd = w_ctrl && wdata_i[RBPT_CTRL_CLR_BIT];
	wire logic        bus_trg = w_ctrl && wdata_i[RBPT_CTRL_BTRG_BIT];
	wire logic        mode_we = w_ctrl && wdata_i[RBPT_CTRL_MODE_WE];
	wire logic [14:0] max_sz  = compact ? MAX_COMPACT : MAX_FULL;
	wire logic [14:0] w_val15 = wdata_i[14:0];
	wire logic        w_hi0   = (wdata_i[30:15] == 16'h0000);

	// Size write legal only between 2 and the element-set maximum
	wire logic size_ok = w_hi0 && (w_val15 >= RBPT_SIZE_MIN) && (w_val15 <= max_sz);
	// Auto sizing may not be turned on while the count is infinite
	wire logic auto_bad = w_auto && wdata_i[0] && m_inf;
	wire logic [16:0] mc_new = wdata_i[16:0];
	// Auto-sized value clamped to what the memory can hold
	wire logic [14:0] mc_size = (mc_new > {2'b00, max_sz}) ? max_sz :
	                            (mc_new < {2'b00, RBPT_SIZE_MIN}) ? RBPT_SIZE_MIN : mc_new[14:0];
	wire logic [14:0] mc_cur  = (mcount > {2'b00, max_sz}) ? max_sz :
	                            (mcount < {2'b00, RBPT_SIZE_MIN}) ? RBPT_SIZE_MIN : mcount[14:0];
	wire logic [6:0]  pct     = wdata_i[RBPT_DEF_BIT] ? RBPT_PCT_DEF : wdata_i[6:0];
	wire logic        pct_bad = w_pct && !wdata_i[RBPT_DEF_BIT] && (wdata_i[30:0] > 31'(RBPT_PCT_MAX));
	wire logic [21:0] pct_prd = 22'(size) * 22'(pct);
	wire logic [14:0] pct_cnt = 15'(pct_prd / RBPT_PCT_DIV);
	// Count above present size is refused
	wire logic pcnt_bad = w_pcnt && !wdata_i[RBPT_DEF_BIT] && (!w_hi0 || (w_val15 > size));
	wire logic any_err  = (w_size && !size_ok) || auto_bad || pct_bad || pcnt_bad;

	// ----------------------------------------------------------------
	// Pre-event source and reading source
	// ----------------------------------------------------------------
	// The link line is picked by the trigger configuration field
	wire logic link_hit = (32'(link_sel) < LINK_LINES) ? link_trig_i[link_sel] : 1'b0;
	wire logic evt = (psrc == RBPT_SRC_EXT)                        ? ext_trig_i :
	                 (psrc == RBPT_SRC_CHAINED_INSTRUMENT_TRIGGER) ? link_hit :
	                 (psrc == RBPT_SRC_BUS)                        ? bus_trg : key_trig_i;
	// Source none storage_disabled_mode offers a reading, whatever the mode
	wire logic sample_v = (feed == RBPT_FEED_RAW)               ? raw_valid_i :
	                      (feed == RBPT_FEED_MATH_RESULT_SOURCE) ? math_valid_i : 1'b0;
	wire logic [DATA_W-1:0] sample_d = (feed == RBPT_FEED_RAW) ? raw_data_i : math_data_i;

	// ----------------------------------------------------------------
	// Storage sequencing
	// ----------------------------------------------------------------
	wire logic running  = (state == RBPT_S_RUN) || (state == RBPT_S_POST);
	wire logic pre_evt  = (state == RBPT_S_RUN) && (mode == RBPT_MODE_PRE) && evt;
	wire logic pre_full = pre_cnt >= size;
	// On the event the post part starts right after the pre-event part
	wire logic [14:0] wloc = pre_evt ? pre_cnt : wptr;
	wire logic do_store = running && sample_v && !abort_i && !clr_cmd && !mode_we
	                      && !(pre_evt && pre_full) && (wloc < size);
	wire logic at_end   = (wloc == size - 15'd1);
	// Relative stamp: zero for the first reading after a start or clear
	wire logic [31:0] stamp = base_set ? (ts_ctr - ts_base) : 32'h0000_0000;
	wire logic [IW-1:0] wl  = wloc[IW-1:0];

	rbpt_state_e next_state;
	logic [14:0] next_wptr;

	// Next state and pointer for the storage sequence
	always_comb begin
		next_state = state;
		next_wptr  = wptr;
		if (mode_we) begin
			next_state = (rbpt_mode_e'(wdata_i[1:0]) == RBPT_STORAGE_DISABLED_MODE) ?
			             RBPT_S_IDLE : RBPT_S_RUN;
			next_wptr  = 15'h0000;
		end else if (abort_i) begin
			next_state = RBPT_S_IDLE;
		end else if (clr_cmd) begin
			next_wptr  = 15'h0000;
		end else if (pre_evt && pre_full) begin
			next_state = RBPT_S_DONE;
		end else begin
			if (pre_evt) begin
				next_state = RBPT_S_POST;
				next_wptr  = pre_cnt;
			end
			if (do_store) begin
				next_wptr = wloc + 15'd1;
				if (at_end) begin
					if (state == RBPT_S_POST || pre_evt || mode == RBPT_MODE_ONCE) begin
						next_state = RBPT_S_DONE;
					end else begin
						next_wptr = 15'h0000;
					end
				end
			end
		end
	end

	// Sequence registers
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state       <= RBPT_S_IDLE;
			wptr        <= 15'h0000;
			triggered_o <= 1'b0;
			storing_o   <= 1'b0;
		end else begin
			state       <= next_state;
			wptr        <= next_wptr;
			storing_o   <= (next_state == RBPT_S_RUN) || (next_state == RBPT_S_POST);
			triggered_o <= mode_we ? 1'b0 : (triggered_o || pre_evt);
		end
	end

	// Entry storage; a clear drops every valid mark but leaves the words
	always_ff @(posedge clk_i) begin
		if (reset_i || clr_cmd) begin
			mem_valid <= '0;
		end else if (do_store) begin
			mem_valid[wl] <= 1'b1;
		end
	end

	// Data, tag and stamp words
	always_ff @(posedge clk_i) begin
		if (do_store) begin
			mem_data[wl] <= sample_d;
			mem_tag[wl]  <= {func_i, chan_i};
			mem_ts[wl]   <= compact ? 32'h0000_0000 : stamp;
		end
	end

	// Time base and stored count; stamp origin taken at the first store
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ts_ctr   <= 32'h0000_0000;
			ts_base  <= 32'h0000_0000;
			base_set <= 1'b0;
			stored   <= 15'h0000;
		end else begin
			ts_ctr <= ts_ctr + 32'h0000_0001;
			if (clr_cmd || mode_we) begin
				base_set <= 1'b0;
			end else if (do_store && !base_set) begin
				base_set <= 1'b1;
				ts_base  <= ts_ctr;
			end
			if (clr_cmd) begin
				stored <= 15'h0000;
			end else if (do_store && !mem_valid[wl]) begin
				stored <= stored + 15'd1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			mode     <= RBPT_STORAGE_DISABLED_MODE;
			feed     <= RBPT_FEED_RAW;
			psrc     <= RBPT_SRC_EXT;
			compact  <= 1'b0;
			link_sel <= 3'h0;
		end else if (w_ctrl) begin
			if (mode_we) begin
				mode <= rbpt_mode_e'(wdata_i[RBPT_CTRL_MODE_LSB +: 2]);
			end
			feed     <= rbpt_feed_e'(wdata_i[RBPT_CTRL_FEED_LSB +: 2]);
			psrc     <= rbpt_src_e'(wdata_i[RBPT_CTRL_PSRC_LSB +: 2]);
			compact  <= wdata_i[RBPT_CTRL_EGRP_BIT];
			link_sel <= wdata_i[RBPT_CTRL_LINK_LSB +: 3];
		end
	end

	// Size, auto sizing and measure count
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			size    <= RBPT_SIZE_RST;
			auto_en <= 1'b0;
			mcount  <= RBPT_MCOUNT_RST;
			m_inf   <= 1'b0;
		end else begin
			if (w_size && size_ok) begin
				size    <= w_val15;
				auto_en <= 1'b0;
			end else if (w_auto && !auto_bad) begin
				auto_en <= wdata_i[0];
				if (wdata_i[0]) begin
					size <= mc_cur;
				end
			end else if (w_mcnt) begin
				mcount <= mc_new;
				m_inf  <= wdata_i[RBPT_INF_BIT];
				if (auto_en && !wdata_i[RBPT_INF_BIT]) begin
					size <= mc_size;
				end
			end
		end
	end

	// Pre-event amount; a shrinking size pulls the amount down with it
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pre_cnt <= RBPT_PRE_RST;
		end else if (w_pct && !pct_bad) begin
			pre_cnt <= pct_cnt;
		end else if (w_pcnt && !pcnt_bad) begin
			pre_cnt <= wdata_i[RBPT_DEF_BIT] ? (size >> 1) : w_val15;
		end else if (pre_cnt > size) begin
			pre_cnt <= size;
		end
	end

	// Sticky error; a new fault in the clearing write still sets it
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			error_o <= 1'b0;
		end else begin
			error_o <= any_err || (error_o && !(w_stat && wdata_i[0]));
		end
	end

	// ----------------------------------------------------------------
	// Read path, answer in the cycle after the strobe
	// ----------------------------------------------------------------
	wire logic [31:0] resv  = 32'(size) * (compact ? CMP_BYTES : FULL_BYTES);
	wire logic [31:0] avail = (MEM_BYTES > resv) ? (MEM_BYTES - resv) : 32'h0000_0000;
	wire logic [IW-1:0] ri  = rd_idx[IW-1:0];
	wire logic        ri_ok = (32'(rd_idx) < DEPTH);
	wire logic [31:0] ctrl_rd = {13'h0000, auto_en, 7'h00, link_sel, 1'b0, psrc,
	                             compact, feed, mode};
	logic [31:0] rmux;

	// Read selection; unmapped offsets answer zero
	always_comb begin
		case (addr_i)
			RBPT_OFF_CTRL:     rmux = ctrl_rd;
			RBPT_OFF_SIZE:     rmux = {17'h00000, size};
			RBPT_OFF_AUTO:     rmux = {31'h0, auto_en};
			RBPT_OFF_MCOUNT:   rmux = {m_inf, 14'h0000, mcount};
			RBPT_OFF_PRE_PCT:  rmux = {17'h00000, pre_cnt};
			RBPT_OFF_PRE_CNT:  rmux = {17'h00000, pre_cnt};
			RBPT_OFF_STATUS:   rmux = {error_o, triggered_o, storing_o, 12'h000,
			                           2'(state), stored};
			RBPT_OFF_FREE:     rmux = avail;
			RBPT_OFF_RESERVED: rmux = resv;
			RBPT_OFF_RD_INDEX: rmux = {17'h00000, wptr};
			RBPT_OFF_RD_DATA:  rmux = ri_ok ? 32'(mem_data[ri]) : 32'h0000_0000;
			RBPT_OFF_RD_TAG:   rmux = ri_ok ? {mem_valid[ri], 4'h0, rd_idx, mem_tag[ri]} : 32'h0;
			RBPT_OFF_RD_TS:    rmux = ri_ok ? mem_ts[ri] : 32'h0000_0000;
			default:           rmux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rdata_o <= 32'h0000_0000;
			rd_idx  <= 15'h0000;
		end else begin
			rdata_o <= rd_i ? rmux : 32'h0000_0000;
			if (w_ridx) begin
				rd_idx <= w_val15;
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_clear_empties;
		@(posedge clk_i) disable iff (reset_i) clr_cmd |=> (mem_valid == '0) && (stored == 15'h0);
	endproperty
	a_clear_empties: assert property (p_clear_empties) else $error("clear left valid entries");

	property p_size_write;
		@(posedge clk_i) disable iff (reset_i)
			(w_size && size_ok) |=> (size == $past(w_val15)) && !auto_en;
	endproperty
	a_size_write: assert property (p_size_write) else $error("size write not applied");

	property p_auto_inf;
		@(posedge clk_i) disable iff (reset_i) auto_bad |=> error_o && $stable(auto_en);
	endproperty
	a_auto_inf: assert property (p_auto_inf) else $error("auto enable with infinite count");

	property p_auto_follow;
		@(posedge clk_i) disable iff (reset_i)
			(w_mcnt && auto_en && !wdata_i[RBPT_INF_BIT]) |=> (size == $past(mc_size));
	endproperty
	a_auto_follow: assert property (p_auto_follow) else $error("size did not follow count");

	property p_auto_off;
		@(posedge clk_i) disable iff (reset_i) (w_auto && !wdata_i[0]) |=> $stable(size);
	endproperty
	a_auto_off: assert property (p_auto_off) else $error("size moved on auto off");

	property p_none_feed;
		@(posedge clk_i) disable iff (reset_i) (feed == RBPT_FEED_NONE) |-> !do_store;
	endproperty
	a_none_feed: assert property (p_none_feed) else $error("stored with source none");

	property p_pcnt_bad;
		@(posedge clk_i) disable iff (reset_i) pcnt_bad |=> error_o && $stable(pre_cnt);
	endproperty
	a_pcnt_bad: assert property (p_pcnt_bad) else $error("oversized pre count taken");

	property p_post_start;
		@(posedge clk_i) disable iff (reset_i)
			(pre_evt && !pre_full && !at_end && !abort_i && !clr_cmd && !mode_we)
			|=> (wptr == $past(pre_cnt) + {14'h0000, $past(do_store)})
			&& (state == RBPT_S_POST) && triggered_o;
	endproperty
	a_post_start: assert property (p_post_start) else $error("post part misplaced");

	property p_wrap;
		@(posedge clk_i) disable iff (reset_i)
			(do_store && at_end && state == RBPT_S_RUN && mode == RBPT_MODE_ALWAYS)
			|=> (wptr == 15'h0) && storing_o;
	endproperty
	a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

	property p_once_stop;
		@(posedge clk_i) disable iff (reset_i)
			(do_store && at_end && mode == RBPT_MODE_ONCE) |=> !storing_o ##1 !storing_o;
	endproperty
	a_once_stop: assert property (p_once_stop) else $error("fill-once kept storing");

endmodule // rbpt_buffer

`default_nettype wire

// ### sim/rbpt_meter_model.sv
// Measurement pipeline model that offers raw and math readings
`timescale 1ns/1ns
`default_nettype none

module rbpt_meter_model (
	input  wire logic        clk_i,
	input  wire logic        en_i,
	input  wire logic [31:0] rnd_i,
	output logic             raw_valid_o,
	output logic      [31:0] raw_data_o,
	output logic             math_valid_o,
	output logic      [31:0] math_data_o
);
	logic        valid_q = 1'b0;
	logic [31:0] data_q = 32'h0;

	// ----------------------------------------------------------------
	// Reading stream
	// ----------------------------------------------------------------
	// Readings come back to back or with gaps; between them the data is
	// inverted so a stale word storage_disabled_mode passes for a fresh one
	always @(posedge clk_i) begin
		valid_q <= en_i && rnd_i[1:0] != 2'h0;
		data_q  <= (en_i && rnd_i[1:0] != 2'h0) ? rnd_i : ~rnd_i;
	end
	assign raw_valid_o  = valid_q;
	assign raw_data_o   = data_q;
	assign math_valid_o = valid_q;
	assign math_data_o  = data_q ^ 32'hFFFF0000;  // Math words differ from raw
endmodule // rbpt_meter_model

`default_nettype wire

// ### sim/rbpt_buffer_test.sv
// Self-checking bench of the reading buffer with pre-event capture
`timescale 1ns/1ns
`default_nettype none

module rbpt_buffer_test
	import rbpt_pkg::*;
;
	logic        clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        wr_i = 1'b0, rd_i = 1'b0, en = 1'b0, abort = 1'b0;
	logic [7:0]  addr = 8'h00, evs = 8'h00, chan = 8'h00;
	logic [3:0]  func = 4'h0;
	logic [1:0]  feed = 2'h0;
	logic [31:0] wdata = 32'h0, rnd = 32'h00000061, rdata, rv, mv, d, c;
	logic        raw_v, math_v, storing, trig, err;
	logic [31:0] rq[$], oq[$], tq[$], cyc = 32'h0;
	logic [11:0] tg = 12'h000, ot = 12'h000;
	logic [31:0] sz[4] = '{32'd1, 32'd405, 32'd2, 32'd404};
	logic [7:0]  sel[4] = '{8'h01, 8'h10, 8'h00, 8'h02};
	int          n_mismatch = 0, compares = 0, ev, k;

	rbpt_buffer i_dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .raw_valid_i(raw_v), .raw_data_i(rv),
		.math_valid_i(math_v), .math_data_i(mv), .func_i(func), .chan_i(chan),
		.ext_trig_i(evs[0]), .link_trig_i(evs[7:2]), .key_trig_i(evs[1]), .abort_i(abort),
		.storing_o(storing), .triggered_o(trig), .error_o(err));
	rbpt_meter_model i_meter (.clk_i(clk_i), .en_i(en), .rnd_i(rnd), .raw_valid_o(raw_v),
		.raw_data_o(rv), .math_valid_o(math_v), .math_data_o(mv));

	// ----------------------------------------------------------------
	// Clock, random source and log of readings, from the math feed when feed bit 0 is set, else from the raw feed
	// ----------------------------------------------------------------
	always #50 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		rnd <= xs(rnd);
		cyc <= cyc + 32'h1;
		if (feed[0] ? math_v : raw_v) begin
			rq.push_back(feed[0] ? mv : rv);
			tq.push_back(cyc);
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// ----------------------------------------------------------------
	// Register port, stream and compare tasks
	// ----------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 v = rdata;  // Read data stands only in this cycle
	endtask
	task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
		rd(a, d);
		chk(n, e, d);
	endtask
	task automatic echk(input logic e);
		chk("error_o", {31'h0, e}, {31'h0, err});
		wr(RBPT_OFF_STATUS, 32'h1);
	endtask
	task automatic scnt(input logic [31:0] e);
		rd(RBPT_OFF_STATUS, d);
		chk("stored count", e, {17'h0, d[14:0]});
	endtask
	// A mode write restarts storage, so the log starts afresh with it
	task automatic go(input logic [31:0] v);
		func <= rnd[3:0];
		chan <= rnd[11:4];
		tg = {rnd[3:0], rnd[11:4]};
		wr(RBPT_OFF_CTRL, v | 32'h40000);
		rq.delete();
		tq.delete();
	endtask
	task automatic wn(input int n);
		en <= 1'b1;
		for (int i = 0; i < 400 && rq.size() < n; i++) @(posedge clk_i);
		en <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic widle;
		for (int i = 0; i < 400 && storing !== 1'b0; i++) @(posedge clk_i);
		#1 chk("storing_o", 32'h0, {31'h0, storing});
	endtask
	task automatic pulse(input logic [7:0] v);
		@(posedge clk_i);
		evs <= v;
		@(posedge clk_i);
		evs <= 8'h00;
		#1;
	endtask
	task automatic ent(input int i, input logic [31:0] e);
		wr(RBPT_OFF_RD_INDEX, i);
		rchk("entry data", RBPT_OFF_RD_DATA, e);
		rchk("entry tag", RBPT_OFF_RD_TAG, {1'b1, 4'h0, i[14:0], tg});
	endtask
	task automatic complete_run;
		$display("Mismatches %0d in %0d compares", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Watchdog far beyond the few hundred cycles the sequence needs
	initial begin
		#2000000;
		n_mismatch++;
		complete_run;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk_i);
		reset_i <= 1'b0;
		rchk("size", RBPT_OFF_SIZE, 32'd100);
		rchk("pre count", RBPT_OFF_PRE_CNT, 32'd50);
		rchk("control", RBPT_OFF_CTRL, 32'h0);
		rchk("unmapped", 8'hFC, 32'h0);
		foreach (sz[j]) begin
			wr(RBPT_OFF_SIZE, sz[j]);
			echk(j < 2);
		end
		wr(RBPT_OFF_CTRL, 32'h10);
		wr(RBPT_OFF_SIZE, 32'd2028);
		echk(1'b1);
		wr(RBPT_OFF_SIZE, 32'd2027);
		rchk("reserved", RBPT_OFF_RESERVED, 32'd16216);
		rchk("free", RBPT_OFF_FREE, 32'd0);
		wr(RBPT_OFF_SIZE, 32'd60);
		wr(RBPT_OFF_CTRL, 32'h0);
		rchk("reserved", RBPT_OFF_RESERVED, 32'd720);
		rchk("free", RBPT_OFF_FREE, 32'd15496);
		wr(RBPT_OFF_MCOUNT, 32'd37);
		wr(RBPT_OFF_AUTO, 32'h1);
		rchk("size", RBPT_OFF_SIZE, 32'd37);
		wr(RBPT_OFF_MCOUNT, 32'd41);
		rchk("size", RBPT_OFF_SIZE, 32'd41);
		wr(RBPT_OFF_AUTO, 32'h0);
		rchk("size", RBPT_OFF_SIZE, 32'd41);
		wr(RBPT_OFF_AUTO, 32'h1);
		wr(RBPT_OFF_SIZE, 32'd60);
		rchk("auto", RBPT_OFF_AUTO, 32'h0);
		rchk("size", RBPT_OFF_SIZE, 32'd60);
		wr(RBPT_OFF_MCOUNT, 32'h80000000);
		wr(RBPT_OFF_AUTO, 32'h1);
		echk(1'b1);
		rchk("auto", RBPT_OFF_AUTO, 32'h0);
		wr(RBPT_OFF_PRE_CNT, 32'd60);
		wr(RBPT_OFF_PRE_CNT, 32'd61);
		echk(1'b1);
		rchk("pre count", RBPT_OFF_PRE_CNT, 32'd60);
		wr(RBPT_OFF_PRE_PCT, 32'd101);
		echk(1'b1);
		wr(RBPT_OFF_PRE_PCT, 32'd25);
		rchk("pre count", RBPT_OFF_PRE_CNT, 32'd15);
		wr(RBPT_OFF_PRE_PCT, 32'h80000000);
		rchk("pre count", RBPT_OFF_PRE_CNT, 32'd30);
		wr(RBPT_OFF_PRE_CNT, 32'd7);
		wr(RBPT_OFF_PRE_CNT, 32'h80000000);
		rchk("pre count", RBPT_OFF_PRE_CNT, 32'd30);
		// Fill once from no feed, math feed and raw feed in turn
		wr(RBPT_OFF_SIZE, 32'd4);
		for (int f = 2; f >= 0; f--) begin
			feed <= f[1:0];
			go({28'h0, f[1:0], 2'h1});
			wn(6);
			if (f == 2) begin
				scnt(32'd0);
			end else begin
				widle;
				scnt(32'd4);
				for (k = 0; k < 4; k++) ent(k, rq[k]);
			end
		end
		wr(RBPT_OFF_RD_INDEX, 32'h0);
		rchk("stamp", RBPT_OFF_RD_TS, 32'h0);
		wr(RBPT_OFF_RD_INDEX, 32'h3);
		rchk("stamp", RBPT_OFF_RD_TS, tq[3] - tq[0]);
		// A store aborted early leaves the older tail in place, old tags too
		oq = rq;
		ot = tg;
		go(32'h1);
		wn(2);
		@(posedge clk_i);
		abort <= 1'b1;
		@(posedge clk_i);
		abort <= 1'b0;
		widle;
		for (k = 0; k < 4; k++) begin
			if (k == rq.size()) tg = ot;
			ent(k, k < rq.size() ? rq[k] : oq[k]);
		end
		wr(RBPT_OFF_CTRL, 32'h10000);
		scnt(32'd0);
		wr(RBPT_OFF_RD_INDEX, 32'h0);
		rd(RBPT_OFF_RD_TAG, d);
		chk("entry valid", 32'h0, {31'h0, d[31]});
		wr(RBPT_OFF_SIZE, 32'd3);
		go(32'h2);
		wn(5);
		k = rq.size();
		for (int i = 0; i < 3; i++) ent(i, rq[i + 3 * ((k - 1 - i) / 3)]);
		// Pre-event capture from every event source, wrong sources first
		wr(RBPT_OFF_SIZE, 32'd8);
		wr(RBPT_OFF_PRE_CNT, 32'd3);
		for (int s = 0; s < 4; s++) begin
			c = (32'(s + 1) << 8) | (32'(s) << 5) | 32'h3;
			go(c);
			wn(11);
			ev = rq.size();
			pulse(~sel[s]);
			chk("triggered_o", 32'h0, {31'h0, trig});
			if (s == 2) wr(RBPT_OFF_CTRL, c | 32'h20000);
			else pulse(sel[s]);
			chk("triggered_o", 32'h1, {31'h0, trig});
			wn(ev + 5);
			widle;
			ent(7, rq[ev + 4]);
			ent(3, rq[ev]);
			ent(2, rq[2 + 8 * ((ev - 3) / 8)]);
		end
		complete_run;
	end
endmodule // rbpt_buffer_test

`default_nettype wire
